//--- verilog/scm_pkg.sv
// Package: constants and carriers for the secondary clock mask and speed strap logic
`default_nettype none
package scm_pkg;
   localparam int SCM_NCLK = 10;
   // Register byte addresses
   localparam logic [3:0] SCM_OFS_CTRL = 4'h0;
   localparam logic [3:0] SCM_OFS_CLKDIS = 4'h4;
   localparam logic [3:0] SCM_OFS_STATUS = 4'h8;
   // Field positions
   localparam int SCM_CTRL_SRST = 0;
   localparam int SCM_ST_DONE = 0;
   localparam int SCM_ST_CAP = 1;
   localparam int SCM_ST_PFAST = 2;
   localparam int SCM_ST_SFAST = 3;
   localparam int SCM_ST_HALF = 4;
   localparam int SCM_ST_SRST = 5;
   localparam int SCM_ST_LOADING = 6;
   // Reset values
   localparam logic [31:0] SCM_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] SCM_CLKDIS_RST = 32'h0000_0000;
   // Synchroniser lanes
   localparam int SCM_SY_PRST = 0;
   localparam int SCM_SY_MSK = 1;
   localparam int SCM_SY_SCLK = 2;
   localparam int SCM_SY_CAP = 3;
   localparam int SCM_SY_PFAST = 4;
   localparam int SCM_SY_SFAST = 5;
   localparam int SCM_NSYNC = 6;

   typedef struct packed {
      logic fast_capable_strap;
      logic primary_fast_enable;
      logic secondary_fast_enable;
   } scm_strap_s;

   typedef struct packed {
      logic secondary_fast_enable_o;
      logic secondary_fast_enable_oe;
   } scm_od_s;

   typedef enum logic [2:0] {
      SCM_HOLD = 3'b001,
      SCM_LOAD = 3'b010,
      SCM_DONE = 3'b100
   } scm_state_e;

   function automatic logic [31:0] scm_be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage
`default_nettype wire

//--- verilog/scm_clk_gen.sv
// Module: secondary clock outputs with per-output disable and rate select
`default_nettype none
module scm_clk_gen import scm_pkg::*; #(
   parameter int N = SCM_NCLK
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic half_rate,
   input wire logic [N-1:0] dis,
   output logic [N-1:0] clk_o
);
   logic phase_ff;
   logic sub_ff;
   logic [N-1:0] clk_o_ff;
   wire step = !half_rate || sub_ff;
   wire nxt_phase = step ? !phase_ff : phase_ff;

   initial begin
      if (N < 1 || N > 32) begin
         $error("scm_clk_gen: N out of range");
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_ff <= 1'b0;
         sub_ff <= 1'b0;
         clk_o_ff <= '0;
      end else if (ce) begin
         sub_ff <= !sub_ff;
         phase_ff <= nxt_phase;
         // Disabled outputs park high, never mid-pulse low
         clk_o_ff <= dis | {N{nxt_phase}};
      end
   end
   assign clk_o = clk_o_ff;

   a_dis_high: assert property (@(posedge clk) disable iff (!nrst)
      ce && dis[0] |=> clk_o_ff[0]) else $error("disabled clock not high");
   a_en_toggles: assert property (@(posedge clk) disable iff (!nrst)
      ce && !dis[0] && !half_rate ##1 ce && !dis[0] && !half_rate |=> clk_o_ff[0] != $past(clk_o_ff[0]))
      else $error("enabled clock stuck");
endmodule
`default_nettype wire

//--- verilog/scm_top.sv
// Module: serial clock mask loader, secondary reset, speed straps, Avalon-MM registers
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`default_nettype none
module scm_top import scm_pkg::*; #(
   parameter int N = SCM_NCLK
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic primary_rst_n,
   input wire logic msk_in,
   input wire logic mask_shift_clk,
   input wire scm_strap_s strap,
   output scm_od_s sfe,
   output logic secondary_rst_n,
   output logic [N-1:0] sec_clk_o,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int CW = $clog2(N + 1);
   localparam logic [CW-1:0] LAST = CW'(N - 1);

   initial begin
      if (N < 1 || N > 32) begin
         $error("scm_top: N out of range");
      end
   end

   // Pin inputs, two stages before use
   logic [SCM_NSYNC-1:0] sy1_ff;
   logic [SCM_NSYNC-1:0] sy2_ff;
   logic sclk_d_ff;
   wire [SCM_NSYNC-1:0] pin_vec = {strap.secondary_fast_enable, strap.primary_fast_enable,
                                   strap.fast_capable_strap, mask_shift_clk, msk_in, primary_rst_n};
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sy1_ff <= '0;
         sy2_ff <= '0;
         sclk_d_ff <= 1'b0;
      end else if (ce) begin
         sy1_ff <= pin_vec;
         sy2_ff <= sy1_ff;
         sclk_d_ff <= sy2_ff[SCM_SY_SCLK];
      end
   end
   wire prst_off = sy2_ff[SCM_SY_PRST];
   wire msk_s = sy2_ff[SCM_SY_MSK];
   wire shift_edge = sy2_ff[SCM_SY_SCLK] && !sclk_d_ff;
   wire cap_s = sy2_ff[SCM_SY_CAP];
   wire pfast_s = sy2_ff[SCM_SY_PFAST];
   wire sfast_s = sy2_ff[SCM_SY_SFAST];

   // Registers
   logic [31:0] ctrl_ff;
   logic [N-1:0] clkdis_ff;
   logic [CW-1:0] cnt_ff;
   scm_state_e state_ff;
   scm_state_e nxt_state;
   logic srst_n_ff;
   logic eff_fast_ff;
   logic half_ff;
   scm_od_s sfe_ff;
   logic [31:0] rdata_ff;
   logic wait_ff;

   // Bus decode
   wire bus_req = (avs_read || avs_write) && wait_ff;
   wire bus_acc = (avs_read || avs_write) && !wait_ff;
   wire wr_ctrl = bus_acc && avs_write && avs_address == SCM_OFS_CTRL;
   wire wr_clkdis = bus_acc && avs_write && avs_address == SCM_OFS_CLKDIS;
   wire loading = state_ff == SCM_LOAD;
   wire shift_now = loading && shift_edge;
   wire [N-1:0] shifted = N > 1 ? {msk_s, clkdis_ff[N-1:1]} : msk_s;
   wire [31:0] clkdis_word = 32'(clkdis_ff);
   wire [31:0] clkdis_wr = scm_be_merge(clkdis_word, avs_writedata, avs_byteenable);
   // Status bits, each placed at its named position
   wire [31:0] status_word = (32'(state_ff == SCM_DONE) << SCM_ST_DONE)
                             | (32'(cap_s) << SCM_ST_CAP)
                             | (32'(pfast_s) << SCM_ST_PFAST)
                             | (32'(sfast_s) << SCM_ST_SFAST)
                             | (32'(half_ff) << SCM_ST_HALF)
                             | (32'(!srst_n_ff) << SCM_ST_SRST)
                             | (32'(loading) << SCM_ST_LOADING);
   wire [31:0] rd_mux = avs_address == SCM_OFS_CTRL ? ctrl_ff :
                        avs_address == SCM_OFS_CLKDIS ? clkdis_word :
                        avs_address == SCM_OFS_STATUS ? status_word : 32'h0000_0000;

   // Strap decode: a slow-only part never counts as fast; status still shows the raw primary strap
   wire nxt_eff_fast = pfast_s && cap_s;
   wire nxt_half = eff_fast_ff && !sfast_s;
   wire nxt_srst_n = prst_off && state_ff == SCM_DONE && !ctrl_ff[SCM_CTRL_SRST];

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SCM_HOLD: begin
            // Start only while secondary reset is still asserted
            if (prst_off && !srst_n_ff) begin
               nxt_state = SCM_LOAD;
            end
         end
         SCM_LOAD: begin
            if (!prst_off) begin
               nxt_state = SCM_HOLD;
            end else if (shift_edge && cnt_ff == LAST) begin
               nxt_state = SCM_DONE;
            end
         end
         SCM_DONE: begin
            // Primary reset again restarts the whole load
            if (!prst_off) begin
               nxt_state = SCM_HOLD;
            end
         end
         default: nxt_state = SCM_HOLD;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= SCM_HOLD;
         cnt_ff <= '0;
      end else if (ce) begin
         state_ff <= nxt_state;
         if (!loading) begin
            cnt_ff <= '0;
         end else if (shift_edge) begin
            cnt_ff <= cnt_ff + CW'(1);
         end
      end
   end

   // Shift beats a bus write: the serial mask load must not be lost
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clkdis_ff <= SCM_CLKDIS_RST[N-1:0];
         ctrl_ff <= SCM_CTRL_RST;
      end else if (ce) begin
         if (shift_now) begin
            clkdis_ff <= shifted;
         end else if (wr_clkdis) begin
            clkdis_ff <= clkdis_wr[N-1:0];
         end
         if (wr_ctrl) begin
            ctrl_ff <= scm_be_merge(ctrl_ff, avs_writedata, avs_byteenable) & 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         srst_n_ff <= 1'b0;
         eff_fast_ff <= 1'b0;
         half_ff <= 1'b0;
         sfe_ff <= '{secondary_fast_enable_o: 1'b0, secondary_fast_enable_oe: 1'b1};
      end else if (ce) begin
         srst_n_ff <= nxt_srst_n;
         eff_fast_ff <= nxt_eff_fast;
         half_ff <= nxt_half;
         // Open drain: only ever drives low; released when fast
         sfe_ff <= '{secondary_fast_enable_o: 1'b0, secondary_fast_enable_oe: !eff_fast_ff};
      end
   end

   // One wait cycle on every access, then a single ready beat
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else if (ce) begin
         wait_ff <= !bus_req;
         if (bus_req) begin
            rdata_ff <= avs_read ? rd_mux : 32'h0000_0000;
         end
      end
   end

   scm_clk_gen #(.N(N)) u_clk (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .half_rate(half_ff),
      .dis(clkdis_ff),
      .clk_o(sec_clk_o)
   );

   assign sfe = sfe_ff;
   assign secondary_rst_n = srst_n_ff;
   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;

   a_load_start: assert property (@(posedge clk) disable iff (!nrst)
      ce && state_ff == SCM_HOLD && prst_off && !srst_n_ff |=> state_ff == SCM_LOAD)
      else $error("mask load did not start");
   a_shift_bit: assert property (@(posedge clk) disable iff (!nrst)
      ce && shift_now |=> clkdis_ff[N-1] == $past(msk_s)) else $error("mask bit not shifted in");
   a_done_count: assert property (@(posedge clk) disable iff (!nrst)
      $rose(state_ff == SCM_DONE) |-> $past(cnt_ff) == LAST) else $error("wrong mask length");
   a_srst_hold: assert property (@(posedge clk) disable iff (!nrst)
      state_ff != SCM_DONE || !prst_off |=> !srst_n_ff) else $error("secondary reset released early");
   a_srst_bit: assert property (@(posedge clk) disable iff (!nrst)
      ce && ctrl_ff[SCM_CTRL_SRST] |=> !srst_n_ff) else $error("reset bit ignored");
   a_cap_limit: assert property (@(posedge clk) disable iff (!nrst)
      ce && !cap_s |=> !eff_fast_ff) else $error("fast without capability");
   a_sfe_drive: assert property (@(posedge clk) disable iff (!nrst)
      ce && !eff_fast_ff |=> sfe_ff.secondary_fast_enable_oe && !sfe_ff.secondary_fast_enable_o)
      else $error("speed line not driven low");
   a_sfe_release: assert property (@(posedge clk) disable iff (!nrst)
      ce && eff_fast_ff |=> !sfe_ff.secondary_fast_enable_oe) else $error("speed line not released");
   a_half_rate: assert property (@(posedge clk) disable iff (!nrst)
      ce ##1 ce |-> half_ff == $past(eff_fast_ff && !sfast_s)) else $error("rate select wrong");
   a_bus_wait: assert property (@(posedge clk) disable iff (!nrst)
      ce && bus_req |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing");

   c_load_done: cover property (@(posedge clk) disable iff (!nrst) $rose(state_ff == SCM_DONE));
   c_srst_off: cover property (@(posedge clk) disable iff (!nrst) $rose(srst_n_ff));
   c_half: cover property (@(posedge clk) disable iff (!nrst) half_ff);
   c_sw_disable: cover property (@(posedge clk) disable iff (!nrst) ce && wr_clkdis);
   c_reload: cover property (@(posedge clk) disable iff (!nrst) state_ff == SCM_DONE ##1 state_ff == SCM_HOLD);
endmodule
`default_nettype wire

//--- verification/scm_board.sv
// Board model: serial clock mask source and secondary speed wire
`default_nettype none
module scm_board (
   input wire logic clk,
   input wire logic start,
   input wire logic [9:0] pattern,
   input wire logic [3:0] phase,
   input wire logic oe,
   input wire logic pull_lvl,
   output logic msk_in,
   output logic mask_shift_clk,
   output logic busy,
   output logic wire_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   // Open drain: device pulls low, else the board resistor sets the level
   assign wire_lvl = oe ? 1'b0 : pull_lvl;
   initial begin
      msk_in = 1'b0;
      mask_shift_clk = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (start) begin
            busy <= 1'b1;
            for (int i = 0; i < 10; i++) begin
               msk_in <= pattern[i];
               repeat (phase) @(posedge clk);
               mask_shift_clk <= 1'b1;
               repeat (phase) @(posedge clk);
               mask_shift_clk <= 1'b0;
            end
            repeat (phase) @(posedge clk);
            // Data no longer held: show a changed level, not the last bit
            msk_in <= ~msk_in;
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Testbench: mask loading, secondary reset, speed straps, register access
`default_nettype none
module tb_top import scm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, nrst = 1'b0, prst_n = 1'b0, start = 1'b0, cap = 1'b0, pf = 1'b0, pull = 1'b1;
   logic [9:0] pattern = 10'h000;
   logic [3:0] phase = 4'h3;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0, avs_write = 1'b0, ce = 1'b1;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [3:0] avs_byteenable = 4'hF;
   logic avs_waitrequest, secondary_rst_n, msk, sclk, busy, wlvl;
   logic [SCM_NCLK-1:0] sec_clk_o;
   scm_od_s sfe;
   scm_strap_s strap;
   int bad_count = 0, n_checks = 0, cyc = 0;
   assign strap = '{fast_capable_strap: cap, primary_fast_enable: pf, secondary_fast_enable: wlvl};
   always #2 clk = ~clk;
   scm_top DUT (.clk(clk), .nrst(nrst), .ce(ce), .primary_rst_n(prst_n), .msk_in(msk),
      .mask_shift_clk(sclk), .strap(strap), .sfe(sfe), .secondary_rst_n(secondary_rst_n),
      .sec_clk_o(sec_clk_o), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   scm_board board (.clk(clk), .start(start), .pattern(pattern), .phase(phase),
      .oe(sfe.secondary_fast_enable_oe), .pull_lvl(pull), .msk_in(msk), .mask_shift_clk(sclk),
      .busy(busy), .wire_lvl(wlvl));
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      // The whole run takes under a thousand cycles; this bound only catches hangs
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // One wait cycle: the answer is sampled at the second edge
      chk(n, 32'h2);
   endtask
   task automatic load(input logic [9:0] pat, input logic [3:0] ph);
      int n;
      logic [9:0] a_or, a_and;
      n = 0;
      a_or = 10'h000;
      a_and = 10'h3FF;
      @(posedge clk);
      prst_n <= 1'b0;
      pattern <= pat;
      phase <= ph;
      repeat (6) @(posedge clk);
      chk({31'h0, secondary_rst_n}, 32'h0);
      prst_n <= 1'b1;
      repeat (4) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy && n < 400) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (secondary_rst_n !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, secondary_rst_n}, 32'h1);
      bus(1'b0, SCM_OFS_CLKDIS, 32'h0, q);
      chk(q, {22'h0, pat});
      repeat (8) begin
         @(posedge clk);
         a_or = a_or | sec_clk_o;
         a_and = a_and & sec_clk_o;
      end
      // Disabled outputs sit high; enabled ones both rise and fall
      chk({22'h0, a_and}, {22'h0, pat});
      chk({22'h0, a_or}, 32'h3FF);
   endtask
   initial begin
      int rises;
      logic p;
      repeat (12) @(posedge clk);
      chk({30'h0, secondary_rst_n, avs_waitrequest}, 32'h1);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      bus(1'b0, SCM_OFS_CTRL, 32'h0, q);
      chk(q, SCM_CTRL_RST);
      bus(1'b0, 4'hC, 32'h0, q);
      chk(q, 32'h0);
      load(10'h2A5, 4'h3);
      load(10'h000, 4'h8);
      load(10'h3FF, 4'h3);
      load(10'h15A, 4'h5);
      bus(1'b1, SCM_OFS_CTRL, 32'hFFFF_FFFF, q);
      bus(1'b0, SCM_OFS_CTRL, 32'h0, q);
      chk(q, 32'h1);
      repeat (4) @(posedge clk);
      chk({31'h0, secondary_rst_n}, 32'h0);
      bus(1'b1, SCM_OFS_CTRL, 32'h0, q);
      repeat (4) @(posedge clk);
      chk({31'h0, secondary_rst_n}, 32'h1);
      for (int k = 0; k < 8; k++) begin
         cap <= k[0];
         pf <= k[1];
         pull <= k[2];
         repeat (10) @(posedge clk);
         chk({31'h0, sfe.secondary_fast_enable_oe}, {31'h0, ~(k[0] & k[1])});
         chk({31'h0, sfe.secondary_fast_enable_o}, 32'h0);
         bus(1'b0, SCM_OFS_STATUS, 32'h0, q);
         chk({27'h0, q[4:1]}, {27'h0, (k[0] & k[1] & ~k[2]), (k[0] & k[1] & k[2]), k[1], k[0]});
         rises = 0;
         p = sec_clk_o[0];
         repeat (16) begin
            @(posedge clk);
            if (sec_clk_o[0] === 1'b1 && p === 1'b0) rises++;
            p = sec_clk_o[0];
         end
         chk(rises, (k[0] & k[1] & ~k[2]) ? 32'h4 : 32'h8);
      end
      // Software disables; a lane outside the byte enables keeps its bits
      bus(1'b1, SCM_OFS_CLKDIS, 32'hFFFF_FC03, q);
      bus(1'b0, SCM_OFS_CLKDIS, 32'h0, q);
      chk(q, 32'h0000_0003);
      avs_byteenable <= 4'h2;
      bus(1'b1, SCM_OFS_CLKDIS, 32'h0000_0200, q);
      avs_byteenable <= 4'hF;
      bus(1'b0, SCM_OFS_CLKDIS, 32'h0, q);
      chk(q, 32'h0000_0203);
      chk({22'h0, sec_clk_o & 10'h203}, 32'h0000_0203);
      // Enable low freezes the clocks; odd edge count so a toggle would show
      ce <= 1'b0;
      @(posedge clk);
      q = {22'h0, sec_clk_o};
      repeat (3) @(posedge clk);
      chk({22'h0, sec_clk_o}, q);
      ce <= 1'b1;
      wrap_up();
   end
endmodule
`default_nettype wire
